// File: hdl/adc_core_ready_and_trigger_select.sv
// Converter core warm-up, ready interrupt and per-input trigger source selection
`timescale 1ns/1ps
module adc_core_ready_and_trigger_select
   import adc_ctl_pkg::*;
#(
   // Highest warm-up code honoured; lower it in simulation to shorten long waits
   parameter logic [3:0] WARM_CODE_CAP = 4'hF
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [adc_ctl_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [adc_ctl_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [adc_ctl_pkg::DATA_W-1:0] reg_rdata,
   // On-chip trigger producers
   input wire logic pwm_special_trig,
   input wire logic [adc_ctl_pkg::NUM_PWM_GEN-1:0] pwm_primary_trig,
   input wire logic pwm_sec_special_trig,
   input wire logic [adc_ctl_pkg::NUM_PWM_GEN-1:0] pwm_secondary_trig,
   input wire logic [adc_ctl_pkg::NUM_PWM_GEN-1:0] pwm_climit_trig,
   input wire logic timer1_period_match,
   input wire logic timer2_period_match,
   input wire logic oc1_trig,
   input wire logic oc2_trig,
   // External trigger pin
   input wire logic external_trigger_pin,
   // Results
   output logic [adc_ctl_pkg::NUM_INPUTS-1:0] input_trigger,
   output logic [adc_ctl_pkg::NUM_CORES-1:0] core_ready,
   output logic irq
);

   // Reset release through two flip-flops
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // External pin synchroniser; only the second stage is read
   logic ext_meta_r;
   logic ext_sync_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
      end else begin
         ext_meta_r <= external_trigger_pin;
         ext_sync_r <= ext_meta_r;
      end
   end

   // Register state
   logic [3:0] core_warmup_delay_r;
   logic [3:0] core_warmup_delay_nxt;
   logic shared_core_ready_int_en_r;
   logic shared_core_ready_int_en_nxt;
   logic [CORE_EN_MSB:0] core_ready_int_en_r;
   logic [CORE_EN_MSB:0] core_ready_int_en_nxt;
   logic [SEL_W-1:0] sel_r [NUM_INPUTS];
   logic [SEL_W-1:0] sel_nxt [NUM_INPUTS];
   logic [NUM_CORES-1:0] power_r;
   logic [NUM_CORES-1:0] power_nxt;
   logic [NUM_CORES-1:0] stat_r;
   logic [NUM_CORES-1:0] stat_nxt;
   logic [NUM_CORES-1:0] mask_r;
   logic [NUM_CORES-1:0] mask_nxt;
   logic sw_common_r;
   logic sw_common_nxt;
   logic sw_level_r;
   logic sw_level_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [NUM_CORES-1:0] ready_prev_r;
   logic [NUM_INPUTS-1:0] trig_r;
   logic [NUM_INPUTS-1:0] trig_nxt;

   logic [NUM_CORES-1:0] ready_w;
   logic [NUM_CORES-1:0] ready_en;
   logic [NUM_CORES-1:0] ready_evt;
   logic [WARM_CNT_W-1:0] delay_periods;
   logic [3:0] warm_code_eff;
   logic [31:0] src_vec;

   // Warm-up length: code n means 2^n periods, one period per clk
   always_comb begin
      warm_code_eff = core_warmup_delay_r;
      if (warm_code_eff > WARM_CODE_CAP) begin
         warm_code_eff = WARM_CODE_CAP;
      end
      // Codes below 0100 are not defined; they fall back to the shortest wait
      if (warm_code_eff < WARM_MIN_CODE) begin
         warm_code_eff = WARM_MIN_CODE;
      end
      delay_periods = WARM_ONE << warm_code_eff;
   end

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CORES; gc++) begin : g_core
         core_warmup_timer u_timer (
            .clk(clk),
            .rst_n(rst_n_r),
            .power_on(power_r[gc]),
            .delay_periods(delay_periods),
            .ready(ready_w[gc])
         );
      end
   endgenerate

   // Ready enables: dedicated cores in bits 3:0, shared core apart
   assign ready_en = {shared_core_ready_int_en_r, core_ready_int_en_r};
   assign ready_evt = ready_w & ~ready_prev_r & ready_en;

   // Trigger source table indexed by selector code; reserved codes stay low
   always_comb begin
      src_vec = '0;
      src_vec[TRG_NONE] = 1'b0;
      src_vec[TRG_SW_COMMON] = sw_common_r;
      src_vec[TRG_SW_LEVEL] = sw_level_r;
      src_vec[TRG_EXT_PIN] = ext_sync_r;
      src_vec[TRG_PWM_SPECIAL] = pwm_special_trig;
      src_vec[TRG_TMR1_PERIOD] = timer1_period_match;
      src_vec[TRG_TMR2_PERIOD] = timer2_period_match;
      src_vec[TRG_PWM_SEC_SPECIAL] = pwm_sec_special_trig;
      src_vec[TRG_OC1] = oc1_trig;
      src_vec[TRG_OC2] = oc2_trig;
      for (int g = 0; g < NUM_PWM_GEN; g++) begin
         src_vec[int'(TRG_PWM_PRI_FIRST) + g] = pwm_primary_trig[g];
         src_vec[int'(TRG_PWM_SEC_FIRST) + g] = pwm_secondary_trig[g];
         src_vec[int'(TRG_PWM_CL_FIRST) + g] = pwm_climit_trig[g];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
         always_comb begin
            trig_nxt[gi] = src_vec[sel_r[gi]];
         end
      end
   endgenerate

   // Register writes, read-clear of status, read mux
   always_comb begin
      logic [3:0] rel;
      rel = reg_addr - OFF_TRIG_SEL_FIRST;
      core_warmup_delay_nxt = core_warmup_delay_r;
      shared_core_ready_int_en_nxt = shared_core_ready_int_en_r;
      core_ready_int_en_nxt = core_ready_int_en_r;
      sel_nxt = sel_r;
      power_nxt = power_r;
      mask_nxt = mask_r;
      sw_level_nxt = sw_level_r;
      sw_common_nxt = 1'b0;
      stat_nxt = stat_r;
      rdata_nxt = rdata_r;
      if (reg_wr) begin
         if (reg_addr == OFF_CTRL_FIVE_HIGH) begin
            core_warmup_delay_nxt = reg_wdata[WARM_LSB +: WARM_W];
            shared_core_ready_int_en_nxt = reg_wdata[SHARED_EN_BIT];
            core_ready_int_en_nxt = reg_wdata[CORE_EN_MSB:0];
         end else if (reg_addr >= OFF_TRIG_SEL_FIRST && reg_addr <= OFF_TRIG_SEL_LAST) begin
            sel_nxt[2 * int'(rel)] = reg_wdata[SEL_LO_LSB +: SEL_W];
            sel_nxt[2 * int'(rel) + 1] = reg_wdata[SEL_HI_LSB +: SEL_W];
         end else if (reg_addr == OFF_CORE_POWER) begin
            power_nxt = reg_wdata[NUM_CORES-1:0];
         end else if (reg_addr == OFF_INT_MASK) begin
            mask_nxt = reg_wdata[NUM_CORES-1:0];
         end else if (reg_addr == OFF_SW_TRIGGER) begin
            sw_common_nxt = reg_wdata[SW_COMMON_BIT];
            sw_level_nxt = reg_wdata[SW_LEVEL_BIT];
         end
      end
      if (reg_rd) begin
         rdata_nxt = '0;
         if (reg_addr == OFF_CTRL_FIVE_HIGH) begin
            rdata_nxt[WARM_LSB +: WARM_W] = core_warmup_delay_r;
            rdata_nxt[SHARED_EN_BIT] = shared_core_ready_int_en_r;
            rdata_nxt[CORE_EN_MSB:0] = core_ready_int_en_r;
         end else if (reg_addr >= OFF_TRIG_SEL_FIRST && reg_addr <= OFF_TRIG_SEL_LAST) begin
            rdata_nxt[SEL_LO_LSB +: SEL_W] = sel_r[2 * int'(rel)];
            rdata_nxt[SEL_HI_LSB +: SEL_W] = sel_r[2 * int'(rel) + 1];
         end else if (reg_addr == OFF_CORE_POWER) begin
            rdata_nxt[NUM_CORES-1:0] = power_r;
         end else if (reg_addr == OFF_CORE_READY) begin
            rdata_nxt[NUM_CORES-1:0] = ready_w;
         end else if (reg_addr == OFF_INT_STATUS) begin
            rdata_nxt[NUM_CORES-1:0] = stat_r;
            stat_nxt = '0;
         end else if (reg_addr == OFF_INT_MASK) begin
            rdata_nxt[NUM_CORES-1:0] = mask_r;
         end else if (reg_addr == OFF_SW_TRIGGER) begin
            rdata_nxt[SW_LEVEL_BIT] = sw_level_r;
         end
      end
      // A ready event in the clearing cycle must survive the read
      stat_nxt = stat_nxt | ready_evt;
      irq_nxt = |(stat_r & mask_r);
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         core_warmup_delay_r <= CTRL_RESET[WARM_LSB +: WARM_W];
         shared_core_ready_int_en_r <= CTRL_RESET[SHARED_EN_BIT];
         core_ready_int_en_r <= CTRL_RESET[CORE_EN_MSB:0];
         for (int i = 0; i < NUM_INPUTS; i++) begin
            sel_r[i] <= TRIG_SEL_RESET[SEL_W-1:0];
         end
         power_r <= CORE_VEC_RESET;
         stat_r <= CORE_VEC_RESET;
         mask_r <= INT_MASK_RESET;
         sw_common_r <= SW_TRIG_RESET[SW_COMMON_BIT];
         sw_level_r <= SW_TRIG_RESET[SW_LEVEL_BIT];
         rdata_r <= '0;
         irq_r <= 1'b0;
         ready_prev_r <= CORE_VEC_RESET;
         trig_r <= '0;
      end else begin
         core_warmup_delay_r <= core_warmup_delay_nxt;
         shared_core_ready_int_en_r <= shared_core_ready_int_en_nxt;
         core_ready_int_en_r <= core_ready_int_en_nxt;
         sel_r <= sel_nxt;
         power_r <= power_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         sw_common_r <= sw_common_nxt;
         sw_level_r <= sw_level_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
         ready_prev_r <= ready_w;
         trig_r <= trig_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign input_trigger = trig_r;
   assign core_ready = ready_w;

endmodule

// File: hdl/core_warmup_timer.sv
// Warm-up delay counter for one converter core
`timescale 1ns/1ps
module core_warmup_timer
   import adc_ctl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic power_on,
   input wire logic [adc_ctl_pkg::WARM_CNT_W-1:0] delay_periods,
   // Status
   output logic ready
);

   logic [WARM_CNT_W-1:0] cnt_r;
   logic [WARM_CNT_W-1:0] cnt_nxt;
   logic ready_r;
   logic ready_nxt;

   // Power removal drops ready on the next clock and restarts the wait
   always_comb begin
      cnt_nxt = cnt_r;
      ready_nxt = ready_r;
      if (!power_on) begin
         cnt_nxt = '0;
         ready_nxt = 1'b0;
      end else if (!ready_r) begin
         if (cnt_r == delay_periods - WARM_ONE) begin
            ready_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + WARM_ONE;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         ready_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ready_r <= ready_nxt;
      end
   end

   assign ready = ready_r;

endmodule

// File: pkg/adc_ctl_pkg.sv
// Constants shared by the converter core ready and trigger select logic
package adc_ctl_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets on the plain register port
   localparam logic [3:0] OFF_CTRL_FIVE_HIGH = 4'h0;
   localparam logic [3:0] OFF_TRIG_SEL_FIRST = 4'h1;
   localparam logic [3:0] OFF_TRIG_SEL_LAST = 4'h6;
   localparam logic [3:0] OFF_CORE_POWER = 4'h7;
   localparam logic [3:0] OFF_CORE_READY = 4'h8;
   localparam logic [3:0] OFF_INT_STATUS = 4'h9;
   localparam logic [3:0] OFF_INT_MASK = 4'hA;
   localparam logic [3:0] OFF_SW_TRIGGER = 4'hB;

   // Cores: dedicated cores 0 to 3, shared core at index 4
   localparam int NUM_CORES = 5;
   localparam int SHARED_CORE = 4;
   localparam int NUM_TRIG_REGS = 6;
   localparam int NUM_INPUTS = 12;
   localparam int SEL_W = 5;
   localparam int WARM_CNT_W = 16;

   // Field positions in the control register
   localparam int WARM_LSB = 8;
   localparam int WARM_W = 4;
   localparam int SHARED_EN_BIT = 7;
   localparam int CORE_EN_MSB = 3;

   // Field positions in a trigger select register: two inputs per register
   localparam int SEL_LO_LSB = 0;
   localparam int SEL_HI_LSB = 8;

   // Software trigger register bits
   localparam int SW_COMMON_BIT = 0;
   localparam int SW_LEVEL_BIT = 1;

   // Smallest documented warm-up code: 16 periods
   localparam logic [3:0] WARM_MIN_CODE = 4'h4;
   localparam logic [15:0] WARM_ONE = 16'h0001;

   // Values after reset
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] TRIG_SEL_RESET = 16'h0000;
   localparam logic [4:0] CORE_VEC_RESET = 5'h00;
   localparam logic [4:0] INT_MASK_RESET = 5'h1F;
   localparam logic [1:0] SW_TRIG_RESET = 2'h0;

   // Trigger source codes
   localparam logic [4:0] TRG_NONE = 5'h00;
   localparam logic [4:0] TRG_SW_COMMON = 5'h01;
   localparam logic [4:0] TRG_SW_LEVEL = 5'h02;
   localparam logic [4:0] TRG_PWM_SPECIAL = 5'h04;
   localparam logic [4:0] TRG_PWM_PRI_FIRST = 5'h05;
   localparam logic [4:0] TRG_TMR1_PERIOD = 5'h0C;
   localparam logic [4:0] TRG_TMR2_PERIOD = 5'h0D;
   localparam logic [4:0] TRG_PWM_SEC_SPECIAL = 5'h0E;
   localparam logic [4:0] TRG_PWM_SEC_FIRST = 5'h0F;
   localparam logic [4:0] TRG_OC1 = 5'h16;
   localparam logic [4:0] TRG_OC2 = 5'h17;
   localparam logic [4:0] TRG_PWM_CL_FIRST = 5'h18;
   localparam logic [4:0] TRG_EXT_PIN = 5'h1F;
   localparam int NUM_PWM_GEN = 5;

endpackage

// File: test/adc_ctl_checker.sv
// Port assertions for the converter core ready and trigger select block
`timescale 1ns/1ps
module adc_ctl_checker
#(
   parameter logic [3:0] WARM_CODE_CAP = 4'hF
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [adc_ctl_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [adc_ctl_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [adc_ctl_pkg::DATA_W-1:0] reg_rdata,
   // Results
   input wire logic [adc_ctl_pkg::NUM_INPUTS-1:0] input_trigger,
   input wire logic [adc_ctl_pkg::NUM_CORES-1:0] core_ready,
   input wire logic irq
);
   import adc_ctl_pkg::*;
   localparam int MAX_WAIT = (1 << WARM_CODE_CAP) + 2;
   logic [15:0] wait_r, wait_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Cycles since core 0 was last powered up, saturating
   always_comb begin
      wait_nxt = wait_r;
      if (reg_wr && reg_addr == OFF_CORE_POWER && reg_wdata[0])
         wait_nxt = 16'h0001;
      else if (wait_r != 16'h0000 && wait_r != 16'hFFFF)
         wait_nxt = wait_r + 16'h0001;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         wait_r <= 16'h0000;
      else
         wait_r <= wait_nxt;
   end
   sequence status_read_s;
      reg_rd && reg_addr == OFF_INT_STATUS;
   endsequence
   sequence quiet_cores_s;
      $stable(core_ready) [*3];
   endsequence
   ctrl_reserved_zero_a: assert property (
      reg_rd && reg_addr == OFF_CTRL_FIVE_HIGH |=> reg_rdata[15:12] == 4'h0 && reg_rdata[6:4] == 3'h0)
      else $error("control read shows reserved bits set");
   unmapped_read_zero_a: assert property (reg_rd && reg_addr >= 4'hC |=> reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   power_drop_a: assert property (
      reg_wr && reg_addr == OFF_CORE_POWER && !reg_wdata[0] |-> ##[1:2] !core_ready[0])
      else $error("core 0 ready stayed after power down");
   warm_span_a: assert property (
      $rose(core_ready[0]) |-> wait_r >= 16'h0010 && wait_r <= MAX_WAIT)
      else $error("core 0 ready outside warm-up range");
   status_clear_a: assert property (status_read_s ##0 quiet_cores_s |-> ##1 !irq)
      else $error("interrupt stayed after status read");
   reread_zero_a: assert property (
      status_read_s ##0 $stable(core_ready) ##1 status_read_s |=> reg_rdata == 16'h0000)
      else $error("status not cleared by read");
   reset_quiet_a: assert property (
      $rose(reset_n) |-> (core_ready == 5'h00 && !irq && input_trigger == 12'h000) [*2])
      else $error("outputs active right after reset");
endmodule
bind adc_core_ready_and_trigger_select adc_ctl_checker #(.WARM_CODE_CAP(WARM_CODE_CAP)) chk_i (.clk(clk),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .input_trigger(input_trigger), .core_ready(core_ready), .irq(irq));

// File: test/test_adc_core_ready_and_trigger_select.sv
// Self-checking bench for the converter core ready and trigger select block
`timescale 1ns/1ps
module test_adc_core_ready_and_trigger_select;
   import adc_ctl_pkg::*;
   logic clk, reset_n, reg_wr, reg_rd, src_on, irq, sp, ssp, t1, t2, oc1, oc2, pin;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [4:0] pri, sec, clim, core_ready;
   logic [11:0] input_trigger;
   int err_total, n_checks, quiet, hits, sel[NUM_INPUTS], hist[$];
   bit mon_on;
   trig_source_model src (.clk(clk), .active(src_on), .pwm_special_trig(sp), .pwm_primary_trig(pri),
      .pwm_sec_special_trig(ssp), .pwm_secondary_trig(sec), .pwm_climit_trig(clim), .timer1_period_match(t1),
      .timer2_period_match(t2), .oc1_trig(oc1), .oc2_trig(oc2), .external_trigger_pin(pin));
   adc_core_ready_and_trigger_select #(.WARM_CODE_CAP(4'h6)) dut (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pwm_special_trig(sp), .pwm_primary_trig(pri), .pwm_sec_special_trig(ssp), .pwm_secondary_trig(sec),
      .pwm_climit_trig(clim), .timer1_period_match(t1), .timer2_period_match(t2), .oc1_trig(oc1), .oc2_trig(oc2),
      .external_trigger_pin(pin), .input_trigger(input_trigger), .core_ready(core_ready), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (a >= OFF_TRIG_SEL_FIRST && a <= OFF_TRIG_SEL_LAST) begin
         quiet = 4;
         sel[2 * (a - 1)] = d[4:0];
         sel[2 * (a - 1) + 1] = d[12:8];
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), reg_rdata, exp);
   endtask
   // Expected trigger for a selector code, from sources one cycle and three cycles back
   function automatic logic exp_trig(input int code, input int v, input int p);
      case (code)
         4, 5, 6, 7, 8, 9: return v[code - 4];
         12, 13: return v[code - 6];
         14, 15, 16, 17, 18, 19: return v[code == 14 ? 10 : code - 4];
         22, 23: return v[code - 14];
         24, 25, 26, 27, 28: return v[code - 8];
         31: return p[21];
         default: return 1'b0;
      endcase
   endfunction
   // Software never programs a reserved selector code
   function automatic logic [4:0] legal_code(input logic [4:0] c);
      case (c)
         5'h03, 5'h0A, 5'h0B, 5'h14, 5'h15, 5'h1D, 5'h1E: return TRG_NONE;
         default: return c;
      endcase
   endfunction
   always @(posedge clk) begin
      hist.push_front(int'({pin, clim, sec, ssp, oc2, oc1, t2, t1, pri, sp}));
      if (hist.size() > 4)
         void'(hist.pop_back());
      if (quiet > 0)
         quiet--;
      else if (mon_on && hist.size() == 4)
         for (int k = 0; k < NUM_INPUTS; k++)
            if (sel[k] > 2 || sel[k] == 0)
               chk("input trigger", input_trigger[k], exp_trig(sel[k], hist[1], hist[3]));
   end
   task automatic warm(input int i, input int code);
      int n;
      n = 0;
      wr(OFF_CTRL_FIVE_HIGH, {4'h0, 4'(code), 8'h85});
      wr(OFF_CORE_POWER, 16'(1 << i));
      while (core_ready[i] !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
         #1;
      end
      if (n >= 200) begin
         err_total++;
         stop_test();
      end
      chk("warm-up cycles", n, code < 4 ? 16 : 1 << code);
      repeat (2) @(posedge clk);
      #1;
      chk("ready interrupt", irq, i % 2 == 0);
      rdc(OFF_CORE_READY, 16'(1 << i));
      rdc(OFF_INT_STATUS, i % 2 == 0 ? 16'(1 << i) : 16'h0000);
      repeat (2) @(posedge clk);
      #1;
      chk("interrupt after clear", irq, 1'b0);
      wr(OFF_CORE_POWER, 16'h0000);
      @(posedge clk);
      #1;
      chk("ready after power down", core_ready, 5'h00);
   endtask
   initial begin
      {reset_n, reg_wr, reg_rd, src_on, reg_addr, reg_wdata, quiet, err_total, n_checks} = '0;
      foreach (sel[k])
         sel[k] = 0;
      void'($urandom(32'he660_0f01));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(OFF_CTRL_FIVE_HIGH, 16'h0000);
      rdc(OFF_INT_MASK, 16'h001F);
      wr(OFF_CTRL_FIVE_HIGH, 16'hFFFF);
      rdc(OFF_CTRL_FIVE_HIGH, 16'h0F8F);
      wr(4'hD, 16'hFFFF);
      rdc(4'hD, 16'h0000);
      // Two status reads back to back: the second must see a cleared register
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= OFF_INT_STATUS;
      repeat (2) @(posedge clk);
      reg_rd <= 1'b0;
      src_on <= 1'b1;
      mon_on = 1'b1;
      for (int r = 0; r < 8; r++) begin
         for (int a = 0; a < 6; a++)
            wr(4'(a + 1), {3'h0, legal_code(5'(r * 12 + 2 * a + 1)), 3'h0, legal_code(5'(r * 12 + 2 * a))});
         repeat (16) @(posedge clk);
      end
      mon_on = 1'b0;
      src_on <= 1'b0;
      wr(OFF_TRIG_SEL_FIRST, 16'h0201);
      wr(OFF_SW_TRIGGER, 16'h0001);
      hits = 0;
      repeat (4) begin
         @(posedge clk);
         #1;
         hits += int'(input_trigger[0] === 1'b1);
      end
      chk("common software trigger", hits, 1);
      wr(OFF_SW_TRIGGER, 16'h0002);
      repeat (4) @(posedge clk);
      #1;
      chk("level software trigger", input_trigger[1:0], 2'b10);
      rdc(OFF_SW_TRIGGER, 16'h0002);
      wr(OFF_SW_TRIGGER, 16'h0000);
      for (int i = 0; i < NUM_CORES; i++)
         warm(i, i == 0 ? 0 : 4 + i % 3);
      wr(OFF_INT_MASK, 16'h0000);
      wr(OFF_CORE_POWER, 16'h0001);
      repeat (40) @(posedge clk);
      #1;
      chk("masked interrupt", irq, 1'b0);
      wr(OFF_INT_MASK, 16'h001F);
      repeat (2) @(posedge clk);
      #1;
      chk("unmasked interrupt", irq, 1'b1);
      // Back-to-back status reads with an event pending: the first clears it
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= OFF_INT_STATUS;
      @(posedge clk);
      #1;
      chk("status first read", reg_rdata, 16'h0001);
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("status second read", reg_rdata, 16'h0000);
      wr(OFF_CORE_POWER, 16'h0000);
      stop_test();
   end
endmodule

// File: test/trig_source_model.sv
// Model of the on-chip trigger producers and the external trigger pin
`timescale 1ns/1ps
module trig_source_model
(
   // Clock and control
   input wire logic clk,
   input wire logic active,
   // Trigger producers
   output logic pwm_special_trig,
   output logic [adc_ctl_pkg::NUM_PWM_GEN-1:0] pwm_primary_trig,
   output logic pwm_sec_special_trig,
   output logic [adc_ctl_pkg::NUM_PWM_GEN-1:0] pwm_secondary_trig,
   output logic [adc_ctl_pkg::NUM_PWM_GEN-1:0] pwm_climit_trig,
   output logic timer1_period_match,
   output logic timer2_period_match,
   output logic oc1_trig,
   output logic oc2_trig,
   output logic external_trigger_pin
);
   import adc_ctl_pkg::*;
   logic [2:0] pin_cnt_r = 3'h0;
   logic pin_r = 1'b0;
   always @(posedge clk) begin
      pin_cnt_r <= pin_cnt_r + 3'h1;
      {pwm_climit_trig, pwm_secondary_trig, pwm_sec_special_trig, oc2_trig, oc1_trig, timer2_period_match,
         timer1_period_match, pwm_primary_trig, pwm_special_trig} <= active ? 21'($urandom) : 21'h0_0000;
      // The pin is asynchronous, so each level is held long enough for the synchroniser
      if (active && pin_cnt_r == 3'h7)
         pin_r <= ~pin_r;
   end
   // One process owns the pin level; the port only shows it
   assign external_trigger_pin = pin_r;
endmodule
